// ==== verilog/oag_pkg.sv ====
/*
  constants and enumerations for the operand address generator.
  assumes a 24-bit address space and sixteen 8-bit registers per bank.
*/
package oag_pkg;
  localparam int ADDR_W     = 24;
  localparam int PAIR_W     = 16;
  localparam int BYTE_W     = 8;
  localparam int BANK_W     = 3;
  localparam int RIDX_W     = 4;
  localparam int PIDX_W     = 3;
  // byte register numbers of the named operands
  localparam logic [3:0] REG_A_LO  = 4'h1;
  localparam logic [3:0] REG_C_LO  = 4'h2;
  localparam logic [3:0] REG_B_LO  = 4'h3;
  localparam logic [3:0] REG_A_HI  = 4'h5;
  localparam logic [3:0] REG_C_HI  = 4'h6;
  localparam logic [3:0] REG_B_HI  = 4'h7;
  localparam logic [3:0] LEGACY_BYTE_BASE = 4'h4;
  localparam logic [2:0] LEGACY_PAIR_BASE = 3'h2;
  // wide pointer and pair numbers
  localparam logic [2:0] PTR_FOUR  = 3'h4;
  localparam logic [2:0] PTR_SIX   = 3'h6;
  localparam logic [2:0] PTR_SEVEN = 3'h7;
  localparam logic [2:0] PAIR_SIX  = 3'h6;
  localparam logic [2:0] PAIR_SEVEN = 3'h7;
  localparam logic [2:0] LOW_PAIR_MAX = 3'h3;
  // operand sizes in bytes
  localparam logic [1:0] SIZE_BYTE  = 2'h1;
  localparam logic [1:0] SIZE_WORD  = 2'h2;
  localparam logic [1:0] SIZE_TRIPLE = 2'h3;
  localparam logic [ADDR_W-1:0] RESET_ADDR = 24'h000000;

  typedef enum logic [2:0] {
    MODE_INDIRECT  = 3'b000,
    MODE_POST_INC  = 3'b001,
    MODE_POST_DEC  = 3'b010,
    MODE_PAIR_IND  = 3'b011,
    MODE_BASED     = 3'b100,
    MODE_INDEXED   = 3'b101,
    MODE_BASED_IDX = 3'b110,
    MODE_NONE      = 3'b111
  } addr_mode_t;

  typedef enum logic [2:0] {
    OFS_A     = 3'b000,
    OFS_B     = 3'b001,
    OFS_C     = 3'b010,
    OFS_PAIR6 = 3'b011,
    OFS_PAIR7 = 3'b100
  } offset_sel_t;
endpackage : oag_pkg

// ==== verilog/operand_address_generator.sv ====
/*
  operand effective-address generator of the cpu core: decodes the
  addressing mode, names the registers to read and forms the address
  and the pointer write-back one cycle after a request.
  assumes the register file answers the read selects combinationally
  in the request cycle and that inputs are synchronous to clk_sys_i.
*/
`timescale 1ns/1ps
module operand_address_generator (
  // clock, reset, enable
  input  wire logic                          clk_sys_i,
  input  wire logic                          rst_i,
  input  wire logic                          en_i,
  // processor status bits
  input  wire logic [oag_pkg::BANK_W-1:0]    bank_select_bits_i,
  input  wire logic                          legacy_set_select_i,
  // request from the instruction decoder
  input  wire logic                          req_valid_i,
  input  wire oag_pkg::addr_mode_t           mode_i,
  input  wire logic [1:0]                    ptr_code_i,
  input  wire logic                          base_is_sp_i,
  input  wire logic [oag_pkg::PIDX_W-1:0]    pair_code_i,
  input  wire oag_pkg::offset_sel_t          offset_sel_i,
  input  wire logic [oag_pkg::BYTE_W-1:0]    disp_i,
  input  wire logic [oag_pkg::ADDR_W-1:0]    index_field_i,
  input  wire logic [1:0]                    size_i,
  input  wire logic                          restricted_class_i,
  input  wire logic                          digit_rotate_op_i,
  // plain register operand decode
  input  wire logic [oag_pkg::RIDX_W-1:0]    byte_code_i,
  output logic      [oag_pkg::RIDX_W-1:0]    byte_reg_idx_o,
  output logic      [oag_pkg::PIDX_W-1:0]    pair_reg_idx_o,
  // push/pop register list, slot five
  input  wire logic                          list_valid_i,
  input  wire logic                          list_user_stack_i,
  input  wire logic                          list_slot5_status_i,
  output logic                               list_illegal_o,
  // register file read selects
  output logic      [oag_pkg::BANK_W-1:0]    rf_bank_o,
  output logic      [oag_pkg::PIDX_W-1:0]    rf_base_ptr_o,
  output logic                               rf_base_sp_o,
  output logic                               rf_base_pair_o,
  output logic      [oag_pkg::RIDX_W-1:0]    rf_ofs_byte_idx_o,
  output logic      [oag_pkg::PIDX_W-1:0]    rf_ofs_pair_idx_o,
  output logic                               rf_ofs_is_pair_o,
  // register file read data
  input  wire logic [oag_pkg::ADDR_W-1:0]    rf_base_data_i,
  input  wire logic [oag_pkg::ADDR_W-1:0]    sp_data_i,
  input  wire logic [oag_pkg::BYTE_W-1:0]    rf_ofs_byte_i,
  input  wire logic [oag_pkg::PAIR_W-1:0]    rf_ofs_pair_i,
  // to the memory access stage
  output logic                               ea_valid_o,
  output logic      [oag_pkg::ADDR_W-1:0]    ea_o,
  output logic                               wb_valid_o,
  output logic      [oag_pkg::BANK_W-1:0]    wb_bank_o,
  output logic      [oag_pkg::PIDX_W-1:0]    wb_ptr_o,
  output logic      [oag_pkg::ADDR_W-1:0]    wb_data_o,
  output logic                               illegal_o
);

  // byte register named A, B or C, remapped by the legacy select
  function automatic logic [3:0] named_byte(input oag_pkg::offset_sel_t sel, input logic legacy);
    logic [3:0] r;
    r = oag_pkg::REG_A_LO;
    case (sel)
      oag_pkg::OFS_A: r = legacy ? oag_pkg::REG_A_HI : oag_pkg::REG_A_LO;
      oag_pkg::OFS_B: r = legacy ? oag_pkg::REG_B_HI : oag_pkg::REG_B_LO;
      oag_pkg::OFS_C: r = legacy ? oag_pkg::REG_C_HI : oag_pkg::REG_C_LO;
      default:        r = oag_pkg::REG_A_LO;
    endcase
    return r;
  endfunction : named_byte

  // decode of the request
  wire logic [2:0] ptr_num     = {1'b1, ptr_code_i};
  wire logic       is_inc      = (mode_i == oag_pkg::MODE_POST_INC);
  wire logic       is_dec      = (mode_i == oag_pkg::MODE_POST_DEC);
  wire logic       is_step     = is_inc | is_dec;
  wire logic       is_pair_ind = (mode_i == oag_pkg::MODE_PAIR_IND);
  wire logic       is_based    = (mode_i == oag_pkg::MODE_BASED);
  wire logic       is_indexed  = (mode_i == oag_pkg::MODE_INDEXED);
  wire logic       is_bidx     = (mode_i == oag_pkg::MODE_BASED_IDX);
  wire logic       ofs_pair    = (offset_sel_i == oag_pkg::OFS_PAIR6) || (offset_sel_i == oag_pkg::OFS_PAIR7);
  wire logic       ofs_byte_ab = (offset_sel_i == oag_pkg::OFS_A) || (offset_sel_i == oag_pkg::OFS_B);
  wire logic       ofs_byte    = ofs_byte_ab || (offset_sel_i == oag_pkg::OFS_C);

  // legality checks
  wire logic step_ok  = ((ptr_num == oag_pkg::PTR_SIX)
                        || (ptr_num == oag_pkg::PTR_SEVEN && !restricted_class_i))
                        && (size_i != 2'h0);
  wire logic pair_ok  = (pair_code_i <= oag_pkg::LOW_PAIR_MAX)
                        && digit_rotate_op_i;
  wire logic based_ok = 1'b1;
  wire logic idx_ok   = ofs_byte_ab || ofs_pair;
  wire logic bidx_ok  = (((ptr_num == oag_pkg::PTR_SIX) || (ptr_num == oag_pkg::PTR_SEVEN))
                        && ofs_byte && !base_is_sp_i)
                        || ((ptr_num == oag_pkg::PTR_FOUR) && ofs_pair && !base_is_sp_i);
  wire logic plain_ok = (mode_i == oag_pkg::MODE_INDIRECT) && !base_is_sp_i;
  wire logic mode_ok  = plain_ok
                        || (is_step && step_ok && !base_is_sp_i)
                        || is_pair_ind && pair_ok
                        || (is_based && based_ok)
                        || (is_indexed && idx_ok)
                        || (is_bidx && bidx_ok);

  // register file read selects, all in the current bank
  assign rf_bank_o         = bank_select_bits_i;
  assign rf_base_sp_o      = is_based & base_is_sp_i;
  assign rf_base_pair_o    = is_pair_ind;
  assign rf_base_ptr_o     = is_pair_ind ? pair_code_i : ptr_num;
  assign rf_ofs_is_pair_o  = ofs_pair;
  assign rf_ofs_pair_idx_o = (offset_sel_i == oag_pkg::OFS_PAIR7) ? oag_pkg::PAIR_SEVEN
                                                                   : oag_pkg::PAIR_SIX;
  assign rf_ofs_byte_idx_o = named_byte(offset_sel_i, legacy_set_select_i);

  // plain operand decode; legacy select shifts the named set up
  wire logic byte_low_named = (byte_code_i < oag_pkg::LEGACY_BYTE_BASE);
  wire logic pair_low_named = (pair_code_i < oag_pkg::LEGACY_PAIR_BASE);
  assign byte_reg_idx_o = (legacy_set_select_i && byte_low_named)
                          ? (byte_code_i | oag_pkg::LEGACY_BYTE_BASE) : byte_code_i;
  assign pair_reg_idx_o = (legacy_set_select_i && pair_low_named)
                          ? (pair_code_i | oag_pkg::LEGACY_PAIR_BASE) : pair_code_i;

  // push/pop list: slot five is a pair on the system stack, status on the user one
  assign list_illegal_o = list_valid_i && (list_slot5_status_i != list_user_stack_i);

  // offset operand, zero-extended to the address width
  wire logic [oag_pkg::ADDR_W-1:0] ofs_ext  = ofs_pair ? {8'h00, rf_ofs_pair_i}
                                                       : {16'h0000, rf_ofs_byte_i};
  wire logic [oag_pkg::ADDR_W-1:0] disp_ext = {16'h0000, disp_i};
  wire logic [oag_pkg::ADDR_W-1:0] base_val = rf_base_sp_o ? sp_data_i : rf_base_data_i;
  wire logic [oag_pkg::ADDR_W-1:0] step_ext = {22'h000000, size_i};

  // additions wrap at the top of the address space
  wire logic [oag_pkg::ADDR_W-1:0] ea_based   = base_val + disp_ext;
  wire logic [oag_pkg::ADDR_W-1:0] ea_indexed = index_field_i + ofs_ext;
  wire logic [oag_pkg::ADDR_W-1:0] ea_bidx    = rf_base_data_i + ofs_ext;
  wire logic [oag_pkg::ADDR_W-1:0] ea_pair    = {8'h00, rf_base_data_i[oag_pkg::PAIR_W-1:0]};
  wire logic [oag_pkg::ADDR_W-1:0] ptr_next   = is_inc ? (rf_base_data_i + step_ext)
                                                       : (rf_base_data_i - step_ext);

  logic [oag_pkg::ADDR_W-1:0] ea_sel;
  always_comb begin
    case (mode_i)
      oag_pkg::MODE_INDIRECT:  ea_sel = rf_base_data_i;
      oag_pkg::MODE_POST_INC:  ea_sel = rf_base_data_i;
      oag_pkg::MODE_POST_DEC:  ea_sel = rf_base_data_i;
      oag_pkg::MODE_PAIR_IND:  ea_sel = ea_pair;
      oag_pkg::MODE_BASED:     ea_sel = ea_based;
      oag_pkg::MODE_INDEXED:   ea_sel = ea_indexed;
      oag_pkg::MODE_BASED_IDX: ea_sel = ea_bidx;
      default:                 ea_sel = oag_pkg::RESET_ADDR;
    endcase
  end

  // result registers; an illegal request still answers, flagged, with no write-back
  wire logic take    = req_valid_i;
  wire logic good    = take && mode_ok;
  logic                         ea_valid_q;
  logic [oag_pkg::ADDR_W-1:0]   ea_q;
  logic                         wb_valid_q;
  logic [oag_pkg::BANK_W-1:0]   wb_bank_q;
  logic [oag_pkg::PIDX_W-1:0]   wb_ptr_q;
  logic [oag_pkg::ADDR_W-1:0]   wb_data_q;
  logic                         illegal_q;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ea_valid_q <= 1'b0;
      ea_q       <= oag_pkg::RESET_ADDR;
      wb_valid_q <= 1'b0;
      wb_bank_q  <= 3'h0;
      wb_ptr_q   <= 3'h0;
      wb_data_q  <= oag_pkg::RESET_ADDR;
      illegal_q  <= 1'b0;
    end else if (en_i) begin
      ea_valid_q <= good;
      ea_q       <= good ? ea_sel : ea_q;
      wb_valid_q <= good && is_step;
      wb_bank_q  <= good ? bank_select_bits_i : wb_bank_q;
      wb_ptr_q   <= good ? ptr_num : wb_ptr_q;
      wb_data_q  <= (good && is_step) ? ptr_next : wb_data_q;
      illegal_q  <= take && !mode_ok;
    end
  end

  assign ea_valid_o = ea_valid_q;
  assign ea_o       = ea_q;
  assign wb_valid_o = wb_valid_q;
  assign wb_bank_o  = wb_bank_q;
  assign wb_ptr_o   = wb_ptr_q;
  assign wb_data_o  = wb_data_q;
  assign illegal_o  = illegal_q;

endmodule : operand_address_generator

// ==== sim/rf_model.sv ====
/* register file partner: answers the read selects in the same cycle.
   assumes the selects come combinationally from the generator. */
`timescale 1ns/1ps
module rf_model (
  // read selects
  input  wire logic [2:0]  bank_i, base_ptr_i, ofs_pair_idx_i,
  input  wire logic [3:0]  ofs_byte_idx_i,
  // read data
  output logic      [23:0] base_data_o, sp_data_o,
  output logic      [7:0]  ofs_byte_o,
  output logic      [15:0] ofs_pair_o
);
  // every word but sp_data_o mixes bank and number, so a wrong select shows
  assign base_data_o = {bank_i, 5'h1f, base_ptr_i, 13'h1ff0};
  assign sp_data_o   = 24'hfffff8; // near the top, so sums must wrap
  assign ofs_byte_o  = {ofs_byte_idx_i, 1'b0, bank_i};
  assign ofs_pair_o  = {ofs_pair_idx_i, 10'h3ff, bank_i};
endmodule : rf_model

// ==== sim/oag_chk_assertions.sv ====
/* port assertions for the operand address generator.
   assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module oag_chk (
  // clock, reset and request flags
  input wire logic clk_sys_i, rst_i, en_i, req_valid_i, base_is_sp_i, restricted_class_i, digit_rotate_op_i,
  input wire oag_pkg::addr_mode_t mode_i,
  input wire logic [1:0] ptr_code_i, size_i,
  input wire logic [7:0] disp_i, rf_ofs_byte_i,
  input wire logic [23:0] index_field_i, rf_base_data_i, ea_o, wb_data_o,
  input wire logic [15:0] rf_ofs_pair_i,
  input wire logic [2:0] bank_select_bits_i, rf_bank_o,
  // list check and results
  input wire logic list_valid_i, list_user_stack_i, list_slot5_status_i, list_illegal_o,
  input wire logic rf_ofs_is_pair_o, ea_valid_o, wb_valid_o, illegal_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  wire take = en_i && req_valid_i;
  wire step = mode_i == oag_pkg::MODE_POST_INC || mode_i == oag_pkg::MODE_POST_DEC;
  wire based_req = take && mode_i == oag_pkg::MODE_BASED && !base_is_sp_i;
  wire idx_req = take && mode_i == oag_pkg::MODE_INDEXED;
  bank_follow_a: assert property (rf_bank_o == bank_select_bits_i)
    else $error("bank select not passed on");
  one_answer_a: assert property (take |=> ea_valid_o != illegal_o)
    else $error("request not answered once");
  wb_with_ea_a: assert property (wb_valid_o |-> ea_valid_o)
    else $error("write-back without address");
  step_size_a: assert property ($past(take) && wb_valid_o |-> ($past(mode_i) == oag_pkg::MODE_POST_INC
    ? 24'(wb_data_o - ea_o) : 24'(ea_o - wb_data_o)) == 24'($past(size_i))) else $error("pointer step wrong");
  based_sum_a: assert property ($past(based_req) && ea_valid_o
    |-> ea_o == 24'($past(rf_base_data_i) + $past(disp_i))) else $error("based sum wrong");
  index_sum_a: assert property ($past(idx_req) && ea_valid_o |-> ea_o == 24'($past(index_field_i)
    + ($past(rf_ofs_is_pair_o) ? $past(rf_ofs_pair_i) : 16'($past(rf_ofs_byte_i))))) else $error("index sum wrong");
  restrict_a: assert property (take && step && restricted_class_i && ptr_code_i == 2'h3
    |=> illegal_o && !wb_valid_o) else $error("restricted step accepted");
  rotate_only_a: assert property (take && mode_i == oag_pkg::MODE_PAIR_IND && !digit_rotate_op_i |=> illegal_o)
    else $error("pair indirect accepted without rotate");
  list_rule_a: assert property (list_illegal_o == (list_valid_i && list_slot5_status_i != list_user_stack_i))
    else $error("list check wrong");
  step_seen_c: cover property (wb_valid_o);
  refuse_seen_c: cover property (illegal_o);
  back_to_back_c: cover property (take ##1 take);
endmodule : oag_chk

// ==== sim/operand_address_generator_tb.sv ====
/* self-checking bench for the operand address generator.
   assumes rf_model as register file and oag_chk bound to the design. */
`timescale 1ns/1ps
module operand_address_generator_tb;
  // mode, pointer or pair, offset, disp or index, size, {sp,restr,rot,legacy,illegal}, bank, address
  typedef struct packed {logic [2:0] m, p, o; logic [23:0] v; logic [1:0] sz; logic [4:0] f;
                         logic [2:0] bk; logic [23:0] ea;} row_t;
  logic clk_sys_i = 1'b0, rst_i = 1'b1, en_i = 1'b1, req_valid_i = 1'b0, base_is_sp_i = 1'b0;
  logic legacy_set_select_i = 1'b0, restricted_class_i = 1'b0, digit_rotate_op_i = 1'b0;
  logic list_valid_i = 1'b0, list_user_stack_i = 1'b0, list_slot5_status_i = 1'b0;
  logic [2:0] bank_select_bits_i = 3'h0, pair_code_i = 3'h0;
  logic [1:0] ptr_code_i = 2'h0, size_i = 2'h0;
  logic [7:0] disp_i = 8'h0, rf_ofs_byte_i;
  logic [3:0] byte_code_i = 4'h0, byte_reg_idx_o, rf_ofs_byte_idx_o;
  logic [23:0] index_field_i = 24'h0, ea_o, wb_data_o, rf_base_data_i, sp_data_i;
  oag_pkg::addr_mode_t mode_i = oag_pkg::MODE_NONE;
  oag_pkg::offset_sel_t offset_sel_i = oag_pkg::OFS_A;
  logic list_illegal_o, rf_base_sp_o, rf_base_pair_o, rf_ofs_is_pair_o, ea_valid_o, wb_valid_o, illegal_o;
  logic [2:0] pair_reg_idx_o, rf_bank_o, rf_base_ptr_o, rf_ofs_pair_idx_o, wb_bank_o, wb_ptr_o;
  logic [15:0] rf_ofs_pair_i;
  int err_total = 0, tests_run = 0, cyc = 0, i;
  // back to back rows; wraps near the top of memory are deliberate
  row_t rows [21] = '{
    '{3'h1,3'h6,3'h0,24'h0,2'h1,5'h00,3'h0,24'h1fdff0}, '{3'h1,3'h7,3'h0,24'h0,2'h3,5'h00,3'h7,24'hfffff0},
    '{3'h2,3'h6,3'h0,24'h0,2'h2,5'h00,3'h1,24'h3fdff0}, '{3'h0,3'h4,3'h0,24'h0,2'h1,5'h00,3'h0,24'h1f9ff0},
    '{3'h3,3'h3,3'h0,24'h0,2'h1,5'h04,3'h7,24'h007ff0}, '{3'h4,3'h7,3'h0,24'h20,2'h1,5'h00,3'h7,24'h000010},
    '{3'h4,3'h4,3'h0,24'hff,2'h1,5'h10,3'h0,24'h0000f7}, '{3'h5,3'h4,3'h0,24'hfffff0,2'h1,5'h00,3'h0,24'h0},
    '{3'h5,3'h4,3'h1,24'h123400,2'h1,5'h02,3'h2,24'h123472}, '{3'h5,3'h4,3'h4,24'h10000,2'h1,5'h00,3'h0,24'h1fff8},
    '{3'h6,3'h6,3'h2,24'h0,2'h1,5'h00,3'h0,24'h1fe010}, '{3'h6,3'h7,3'h2,24'h0,2'h1,5'h02,3'h1,24'h400051},
    '{3'h1,3'h7,3'h0,24'h0,2'h1,5'h09,3'h0,24'h0}, '{3'h2,3'h4,3'h0,24'h0,2'h1,5'h01,3'h0,24'h0},
    '{3'h3,3'h0,3'h0,24'h0,2'h1,5'h01,3'h0,24'h0}, '{3'h3,3'h4,3'h0,24'h0,2'h1,5'h05,3'h0,24'h0},
    '{3'h5,3'h4,3'h2,24'h0,2'h1,5'h01,3'h0,24'h0}, '{3'h6,3'h4,3'h0,24'h0,2'h1,5'h01,3'h0,24'h0},
    '{3'h7,3'h4,3'h0,24'h0,2'h1,5'h01,3'h0,24'h0}, '{3'h1,3'h6,3'h0,24'h0,2'h0,5'h01,3'h0,24'h0},
    '{3'h6,3'h4,3'h3,24'h0,2'h1,5'h00,3'h0,24'h207fe8}};
  operand_address_generator u_dut (.*);
  rf_model u_rf (.bank_i(rf_bank_o), .base_ptr_i(rf_base_ptr_o), .ofs_pair_idx_i(rf_ofs_pair_idx_o),
    .ofs_byte_idx_i(rf_ofs_byte_idx_o), .base_data_o(rf_base_data_i), .sp_data_o(sp_data_i),
    .ofs_byte_o(rf_ofs_byte_i), .ofs_pair_o(rf_ofs_pair_i));
  task automatic cmp_val(input string n, input logic [23:0] e, input logic [23:0] s);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask : cmp_val
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  task automatic put_row(input row_t q);
    {mode_i, offset_sel_i} <= {oag_pkg::addr_mode_t'(q.m), oag_pkg::offset_sel_t'(q.o)};
    {ptr_code_i, pair_code_i, disp_i, index_field_i, size_i} <= {q.p[1:0], q.p, q.v[7:0], q.v, q.sz};
    {base_is_sp_i, restricted_class_i, digit_rotate_op_i, legacy_set_select_i} <= q.f[4:1];
    {bank_select_bits_i, req_valid_i} <= {q.bk, 1'b1};
  endtask : put_row
  task automatic check_row(input row_t q);
    logic st;
    st = (q.m == 3'h1 || q.m == 3'h2) && !q.f[0];
    cmp_val("illegal", {23'h0, q.f[0]}, {23'h0, illegal_o});
    cmp_val("ea_valid", {23'h0, !q.f[0]}, {23'h0, ea_valid_o});
    cmp_val("wb_valid", {23'h0, st}, {23'h0, wb_valid_o});
    if (!q.f[0]) cmp_val("ea", q.ea, ea_o);
    if (st) cmp_val("wb_data", q.m == 3'h1 ? q.ea + 24'(q.sz) : q.ea - 24'(q.sz), wb_data_o);
    if (st) cmp_val("wb_sel", {18'h0, q.bk, 1'b1, q.p[1:0]}, {18'h0, wb_bank_o, wb_ptr_o});
  endtask : check_row
  initial begin
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 400) begin
      err_total++;
      give_verdict();
    end
  end
  initial begin
    repeat (10) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    #1 cmp_val("rst_out", 24'h0, ea_o | wb_data_o | {ea_valid_o, wb_valid_o, illegal_o});
    for (i = 0; i < 22; i++) begin
      @(posedge clk_sys_i);
      if (i < 21) put_row(rows[i]);
      else req_valid_i <= 1'b0;
      #1;
      if (i < 21) cmp_val("base_kind", {22'h0, rows[i].m == 3'h3, rows[i].m == 3'h4 && rows[i].f[4]},
                          {22'h0, rf_base_pair_o, rf_base_sp_o});
      if (i > 0) check_row(rows[i-1]);
    end
    // frozen enable must hold the last legal address
    @(posedge clk_sys_i);
    en_i <= 1'b0;
    put_row(rows[0]);
    repeat (3) @(posedge clk_sys_i);
    #1 cmp_val("frozen", {rows[20].ea}, {ea_o[23:1], ea_o[0] | ea_valid_o});
    @(posedge clk_sys_i);
    en_i <= 1'b1;
    @(posedge clk_sys_i);
    req_valid_i <= 1'b0;
    #1 check_row(rows[0]);
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    @(posedge clk_sys_i);
    rst_i <= 1'b0;
    #1 cmp_val("rst_again", 24'h0, ea_o | wb_data_o);
    for (i = 0; i < 32; i++) begin
      @(posedge clk_sys_i);
      {legacy_set_select_i, byte_code_i} <= i[4:0];
      {pair_code_i, list_valid_i, list_user_stack_i, list_slot5_status_i} <= {i[2:0], i[2:0]};
      #1 cmp_val("byte_idx", 24'((i[4] && i[3:0] < 4) ? i[3:0] + 4 : i[3:0]), {20'h0, byte_reg_idx_o});
      cmp_val("pair_idx", 24'((i[4] && i[2:0] < 2) ? i[2:0] + 2 : i[2:0]), {21'h0, pair_reg_idx_o});
      cmp_val("list", {23'h0, i[2] && i[1] != i[0]}, {23'h0, list_illegal_o});
    end
    give_verdict();
  end
endmodule : operand_address_generator_tb
bind operand_address_generator oag_chk u_chk (.*);
